// [spll_pkg.sv]
package spll_pkg;
   // geometry: 64 sectors; sector number sits low in address byte 0
   localparam int SECTORS = 64;
   localparam int SECT_W = 6;
   localparam int SECT_MSB = 5;

   // opcodes; only the protection read code is fixed by the part
   localparam logic [7:0] OP_RD_PROT = 8'h3c;
   localparam logic [7:0] OP_PROTECT = 8'h36;
   localparam logic [7:0] OP_UNPROTECT = 8'h39;
   localparam logic [7:0] OP_WR_STATUS = 8'h01;
   localparam logic [7:0] OP_RD_STATUS = 8'h05;

   // number of address bytes, counted from zero
   localparam logic [1:0] ADDR_LAST = 2'h2;

   // readback bytes for a protection bit
   localparam logic [7:0] PROT_ON_BYTE = 8'hff;
   localparam logic [7:0] PROT_OFF_BYTE = 8'h00;

   // first status byte layout
   localparam int SR_LOCK_BIT = 7;
   localparam int SR_WP_BIT = 4;
   localparam int SR_SUM_MSB = 3;
   localparam int SR_SUM_LSB = 2;
   localparam int SR_GLOB_MSB = 5;
   localparam int SR_GLOB_LSB = 2;
   localparam logic [3:0] GLOB_UNPROTECT = 4'h0;
   localparam logic [3:0] GLOB_PROTECT = 4'hf;

   // summary encodings
   localparam logic [1:0] SUM_NONE = 2'h0;
   localparam logic [1:0] SUM_SOME = 2'h1;
   localparam logic [1:0] SUM_ALL = 2'h3;

   // reset values: power-up with every sector protected and unlocked
   localparam logic [SECTORS-1:0] PROT_RESET = {SECTORS{1'b1}};
   localparam logic LOCK_RESET = 1'b0;
endpackage

// [spll_link_if.sv]
`timescale 1ns/1ns
interface spll_link_if;
   logic byte_stb;
   logic [7:0] rx_byte;
   logic frame_end;
   logic frame_aligned;
   logic active;
   logic out_en;
   logic [7:0] out_byte;

   modport link
   (
      output byte_stb,
      output rx_byte,
      output frame_end,
      output frame_aligned,
      output active,
      input out_en,
      input out_byte
   );

   modport core
   (
      input byte_stb,
      input rx_byte,
      input frame_end,
      input frame_aligned,
      input active,
      output out_en,
      output out_byte
   );
endinterface

// [spll_link.sv]
`timescale 1ns/1ns
module spll_link
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe_n,
   spll_link_if.link lnk
);

   typedef struct packed {
      logic [1:0] sclk_s;
      logic [1:0] cs_s;
      logic [1:0] mosi_s;
      logic sclk_prev;
      logic act;
      logic [7:0] rx_sh;
      logic [2:0] rx_cnt;
      logic [7:0] tx_sh;
      logic [2:0] tx_cnt;
      logic miso;
      logic drive;
      logic byte_stb;
      logic [7:0] rx_byte;
      logic frame_end;
      logic aligned;
   } spll_link_st_t;

   spll_link_st_t q;
   spll_link_st_t d;
   logic rise;
   logic fall;
   logic active;

   // edges seen on the synchronised clock; pins share the same delay
   assign rise = q.sclk_s[1] & ~q.sclk_prev;
   assign fall = ~q.sclk_s[1] & q.sclk_prev;
   assign active = ~q.cs_s[1];

   // shifter: input on rising edges, output on falling edges, msb first
   always_comb
   begin
      d = q;
      d.sclk_s = {q.sclk_s[0], sclk};
      d.cs_s = {q.cs_s[0], cs_n};
      d.mosi_s = {q.mosi_s[0], mosi};
      d.sclk_prev = q.sclk_s[1];
      d.act = active;
      d.byte_stb = 1'b0;
      d.frame_end = 1'b0;
      if (!active)
      begin
         // release may land mid-byte; partial bits are simply dropped
         if (q.act)
         begin
            d.frame_end = 1'b1;
            d.aligned = (q.rx_cnt == 3'h0);
         end
         d.rx_cnt = 3'h0;
         d.tx_cnt = 3'h0;
         d.drive = 1'b0;
      end
      else
      begin
         if (rise)
         begin
            d.rx_sh = {q.rx_sh[6:0], q.mosi_s[1]};
            d.rx_cnt = q.rx_cnt + 3'h1;
            if (q.rx_cnt == 3'h7)
            begin
               d.byte_stb = 1'b1;
               d.rx_byte = {q.rx_sh[6:0], q.mosi_s[1]};
            end
         end
         if (fall && lnk.out_en)
         begin
            // a fresh byte is taken only at a byte start
            if (q.tx_cnt == 3'h0)
            begin
               d.miso = lnk.out_byte[7];
               d.tx_sh = {lnk.out_byte[6:0], 1'b0};
            end
            else
            begin
               d.miso = q.tx_sh[7];
               d.tx_sh = {q.tx_sh[6:0], 1'b0};
            end
            d.tx_cnt = q.tx_cnt + 3'h1;
            d.drive = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         q <= '0;
         q.cs_s <= 2'h3;
      end
      else
      begin
         q <= d;
      end
   end

   assign miso = q.miso;
   assign miso_oe_n = ~q.drive;
   assign lnk.byte_stb = q.byte_stb;
   assign lnk.rx_byte = q.rx_byte;
   assign lnk.frame_end = q.frame_end;
   assign lnk.frame_aligned = q.aligned;
   assign lnk.active = q.act;

endmodule // spll_link

// [spll_top.sv]
// Behaviour
// - then repeat FFh if protected, else 00h
// - one bit per sector, 1 means protected
// - chip select release ends read, output floats
// - release allowed anytime, even mid-byte
// - readback ignores the write-protect pin
// - status shows all, some or no sectors protected
// - pin never changes protection bits directly
// - hardware lock needs pin asserted and lock set
// - hardware lock discards protect, unprotect, status write
// - lock bit set freezes every protection bit
// - clearing lock never performs a global operation
// - pin held asserted: only power cycle clears lock
// - pin released: lock set rejects sector commands
// - setting lock may also do global operation
// - software lock can be cleared, hardware cannot
// - lock zero: 00h,7Fh,FFh,F0h,0Fh decode as listed
// - bits 5..2 decoded, not stored; read shows status
`timescale 1ns/1ns
module spll_top
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic wp_n,
   output logic miso,
   output logic miso_oe_n,
   output logic protection_lock_bit,
   output logic [1:0] protection_summary_bits,
   output logic hw_locked,
   output logic sw_locked
);

   typedef enum logic [2:0] {
      SPLL_CMD = 3'b000,
      SPLL_ADDR = 3'b001,
      SPLL_SEND = 3'b010,
      SPLL_WDATA = 3'b011,
      SPLL_TAIL = 3'b100,
      SPLL_SKIP = 3'b101
   } spll_phase_t;

   typedef struct packed {
      spll_phase_t phase;
      logic [7:0] opcode;
      logic [1:0] addr_cnt;
      logic [spll_pkg::SECT_MSB:0] sector;
      logic [7:0] sr_byte;
      logic cmd_ok;
      logic [spll_pkg::SECTORS-1:0] prot;
      logic lock;
      logic [1:0] wp_s;
      logic out_en;
      logic [1:0] summary;
      logic hw;
      logic sw;
   } spll_st_t;

   spll_st_t q;
   spll_st_t d;
   spll_link_if lnk();
   logic wp_asserted;
   logic hw_now;
   logic [7:0] status_byte;
   logic [3:0] glob;

   spll_link u_link
   (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe_n(miso_oe_n),
      .lnk(lnk)
   );

   // the pin is only ever used as a gate, never as a write source
   assign wp_asserted = ~q.wp_s[1];
   assign hw_now = wp_asserted & q.lock;
   assign glob = q.sr_byte[spll_pkg::SR_GLOB_MSB:spll_pkg::SR_GLOB_LSB];

   // status readback: written bits 5..2 are replaced by live state
   always_comb
   begin
      status_byte = 8'h00;
      status_byte[spll_pkg::SR_LOCK_BIT] = q.lock;
      status_byte[spll_pkg::SR_WP_BIT] = wp_asserted;
      status_byte[spll_pkg::SR_SUM_MSB:spll_pkg::SR_SUM_LSB] = q.summary;
   end

   // command sequencer, protection store and lock control
   always_comb
   begin
      d = q;
      d.wp_s = {q.wp_s[0], wp_n};
      d.hw = hw_now;
      d.sw = ~wp_asserted & q.lock;
      // summary of stored bits, one cycle behind the store
      if (&q.prot)
      begin
         d.summary = spll_pkg::SUM_ALL;
      end
      else if (|q.prot)
      begin
         d.summary = spll_pkg::SUM_SOME;
      end
      else
      begin
         d.summary = spll_pkg::SUM_NONE;
      end

      if (lnk.frame_end)
      begin
         // commands act on release, and only on a whole number of bytes
         d.phase = SPLL_CMD;
         d.out_en = 1'b0;
         d.cmd_ok = 1'b0;
         if (lnk.frame_aligned && q.cmd_ok && !hw_now)
         begin
            if (q.opcode == spll_pkg::OP_PROTECT)
            begin
               if (!q.lock)
               begin
                  d.prot[q.sector] = 1'b1;
               end
            end
            else if (q.opcode == spll_pkg::OP_UNPROTECT)
            begin
               if (!q.lock)
               begin
                  d.prot[q.sector] = 1'b0;
               end
            end
            else if (q.opcode == spll_pkg::OP_WR_STATUS)
            begin
               d.lock = q.sr_byte[spll_pkg::SR_LOCK_BIT];
               // glob is decoded here and never stored
               if (!q.lock)
               begin
                  if (glob == spll_pkg::GLOB_UNPROTECT)
                  begin
                     d.prot = '0;
                  end
                  else if (glob == spll_pkg::GLOB_PROTECT)
                  begin
                     d.prot = '1;
                  end
               end
            end
         end
      end
      else if (lnk.byte_stb)
      begin
         unique case (q.phase)
            SPLL_CMD:
            begin
               d.opcode = lnk.rx_byte;
               d.addr_cnt = 2'h0;
               if (lnk.rx_byte == spll_pkg::OP_RD_PROT ||
                   lnk.rx_byte == spll_pkg::OP_PROTECT ||
                   lnk.rx_byte == spll_pkg::OP_UNPROTECT)
               begin
                  d.phase = SPLL_ADDR;
               end
               else if (lnk.rx_byte == spll_pkg::OP_WR_STATUS)
               begin
                  d.phase = SPLL_WDATA;
               end
               else if (lnk.rx_byte == spll_pkg::OP_RD_STATUS)
               begin
                  d.phase = SPLL_SEND;
                  d.out_en = 1'b1;
               end
               else
               begin
                  d.phase = SPLL_SKIP;
               end
            end
            SPLL_ADDR:
            begin
               // any address inside the sector selects it
               if (q.addr_cnt == 2'h0)
               begin
                  d.sector = lnk.rx_byte[spll_pkg::SECT_MSB:0];
               end
               d.addr_cnt = q.addr_cnt + 2'h1;
               if (q.addr_cnt == spll_pkg::ADDR_LAST)
               begin
                  if (q.opcode == spll_pkg::OP_RD_PROT)
                  begin
                     d.phase = SPLL_SEND;
                     d.out_en = 1'b1;
                  end
                  else
                  begin
                     d.phase = SPLL_TAIL;
                     d.cmd_ok = 1'b1;
                  end
               end
            end
            SPLL_WDATA:
            begin
               // only the first data byte counts, later ones are ignored
               d.sr_byte = lnk.rx_byte;
               d.cmd_ok = 1'b1;
               d.phase = SPLL_TAIL;
            end
            SPLL_SEND, SPLL_TAIL, SPLL_SKIP:
            begin
               d.phase = q.phase;
            end
            default:
            begin
               d.phase = SPLL_SKIP;
            end
         endcase
      end
   end

   // protection read byte follows the stored bit live, never the pin
   always_comb
   begin
      if (q.opcode == spll_pkg::OP_RD_PROT)
      begin
         lnk.out_byte = q.prot[q.sector] ? spll_pkg::PROT_ON_BYTE :
                        spll_pkg::PROT_OFF_BYTE;
      end
      else
      begin
         lnk.out_byte = status_byte;
      end
   end

   assign lnk.out_en = q.out_en;

   // reset stands in for power cycle: lock clears, sectors protected
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         q <= '0;
         q.phase <= SPLL_CMD;
         q.prot <= spll_pkg::PROT_RESET;
         q.lock <= spll_pkg::LOCK_RESET;
         q.wp_s <= 2'h3;
      end
      else
      begin
         q <= d;
      end
   end

   assign protection_lock_bit = q.lock;
   assign protection_summary_bits = q.summary;
   assign hw_locked = q.hw;
   assign sw_locked = q.sw;

endmodule // spll_top

// [spll_top_properties.sv]
`timescale 1ns/1ns
module spll_top_properties
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic wp_n,
   input wire logic miso,
   input wire logic miso_oe_n,
   input wire logic protection_lock_bit,
   input wire logic [1:0] protection_summary_bits,
   input wire logic hw_locked,
   input wire logic sw_locked
);
   // one domain, so one clock and one reset for all
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_oe_idle;
      cs_n[*6] |-> miso_oe_n;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("miso not floating");

   property p_oe_on;
      $fell(miso_oe_n) |-> !cs_n && !$past(cs_n, 8);
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("miso driven off frame");

   // the pin is synchronised, so allow a few cycles before judging
   property p_hw_on;
      (!wp_n && protection_lock_bit)[*5] |-> hw_locked;
   endproperty
   a_hw_on: assert property (p_hw_on)
      else $error("hardware lock missing");

   property p_hw_need;
      hw_locked |-> $past(protection_lock_bit);
   endproperty
   a_hw_need: assert property (p_hw_need)
      else $error("lock flag w/o bit");

   property p_hw_excl;
      hw_locked |-> !sw_locked;
   endproperty
   a_hw_excl: assert property (p_hw_excl)
      else $error("both lock kinds");

   property p_sw_on;
      (wp_n && protection_lock_bit)[*5] |-> sw_locked;
   endproperty
   a_sw_on: assert property (p_sw_on)
      else $error("soft lock missing");

   property p_lock_hold;
      (!wp_n)[*6] ##0 protection_lock_bit |=> protection_lock_bit;
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("lock bit cleared");

   property p_frozen;
      protection_lock_bit[*3] |=> $stable(protection_summary_bits);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("bits moved in lock");

   property p_rst_all;
      $rose(reset_n) |-> ##[0:2] protection_summary_bits == spll_pkg::SUM_ALL;
   endproperty
   a_rst_all: assert property (p_rst_all)
      else $error("not all protected");

   // output bits move only while the serial clock is low
   property p_miso_low;
      $changed(miso) |-> !sclk && !miso_oe_n;
   endproperty
   a_miso_low: assert property (p_miso_low)
      else $error("miso moved off falling edge");
endmodule // spll_top_properties

bind spll_top spll_top_properties chk
(
   .core_clk(core_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
   .mosi(mosi), .wp_n(wp_n), .miso(miso), .miso_oe_n(miso_oe_n),
   .protection_lock_bit(protection_lock_bit),
   .protection_summary_bits(protection_summary_bits),
   .hw_locked(hw_locked), .sw_locked(sw_locked)
);

// [spll_host_model.sv]
`timescale 1ns/1ns
module spll_host_model
(
   input wire logic core_clk,
   input wire logic miso,
   input wire logic miso_oe_n,
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   // mode 0: clock rests low outside frames
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // half a serial period, 4 core cycles, gives 160 ns per bit
   task automatic half();
      repeat (4) @(negedge core_clk);
   endtask

   task automatic open_f();
      cs_n = 1'b0;
      half();
   endtask

   // leave room for the command to land before the next frame
   task automatic close_f();
      cs_n = 1'b1;
      repeat (12) @(negedge core_clk);
   endtask

   // msb first, sample on the rise; a floating line reads unknown
   task automatic shift(input logic [7:0] b, input int n,
                        output logic [7:0] r);
      r = 8'h00;
      for (int i = 7; i > 7 - n; i--)
      begin
         mosi = b[i];
         half();
         sclk = 1'b1;
         r[i] = miso_oe_n ? 1'bx : miso;
         half();
         sclk = 1'b0;
      end
   endtask
endmodule // spll_host_model

// [spll_top_test.sv]
`timescale 1ns/1ns
module spll_top_test;
   logic core_clk = 1'b0;
   logic reset_n, wp_n, sclk, cs_n, mosi, miso, miso_oe_n;
   logic lock, hw_locked, sw_locked;
   logic [1:0] summ;
   logic [7:0] r;
   int error_cnt = 0;
   int tests_run = 0;
   int cycles = 0;

   spll_top dut
   (
      .core_clk(core_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .wp_n(wp_n), .miso(miso), .miso_oe_n(miso_oe_n),
      .protection_lock_bit(lock), .protection_summary_bits(summ),
      .hw_locked(hw_locked), .sw_locked(sw_locked)
   );
   spll_host_model host
   (
      .core_clk(core_clk), .miso(miso), .miso_oe_n(miso_oe_n),
      .sclk(sclk), .cs_n(cs_n), .mosi(mosi)
   );

   // 50 mhz core clock
   always #10 core_clk = ~core_clk;

   // the run needs about 5300 cycles; a hang is cut well past that
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (error_cnt == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic do_reset();
      reset_n = 1'b0;
      repeat (8) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge core_clk);
   endtask

   // opcode, first byte, then zero bytes up to nb; frame may stay open
   task automatic cmd(input logic [7:0] op, input logic [7:0] b0,
                      input int nb, input bit keep);
      host.open_f();
      host.shift(op, 8, r);
      host.shift(b0, 8, r);
      for (int i = 1; i < nb; i++)
         host.shift(8'h00, 8, r);
      if (!keep)
         host.close_f();
   endtask

   task automatic wr_sr(input logic [7:0] b);
      cmd(spll_pkg::OP_WR_STATUS, b, 1, 0);
   endtask

   task automatic st(input logic l, input logic [1:0] s);
      chk({7'h0, lock}, {7'h0, l});
      chk({6'h0, summ}, {6'h0, s});
   endtask

   // status read: bits 5..2 show pin and summary, not what was written
   task automatic rd_sr(input logic [7:0] exp);
      host.open_f();
      host.shift(spll_pkg::OP_RD_STATUS, 8, r);
      host.shift(8'h00, 8, r);
      chk(r, exp);
      host.close_f();
   endtask

   // two repeated bytes, then release and expect a floating line
   task automatic rd_prot(input logic [7:0] s, input logic [7:0] exp);
      cmd(spll_pkg::OP_RD_PROT, s, 3, 1);
      repeat (2)
      begin
         host.shift(8'h00, 8, r);
         chk(r, exp);
      end
      host.close_f();
      chk({7'h0, miso_oe_n}, 8'h01);
   endtask

   task automatic t_sector();
      st(1'b0, spll_pkg::SUM_ALL);
      cmd(spll_pkg::OP_UNPROTECT, 8'hc3, 3, 0);
      rd_prot(8'h03, spll_pkg::PROT_OFF_BYTE);
      rd_prot(8'h04, spll_pkg::PROT_ON_BYTE);
      st(1'b0, spll_pkg::SUM_SOME);
      cmd(spll_pkg::OP_PROTECT, 8'h03, 3, 0);
      st(1'b0, spll_pkg::SUM_ALL);
   endtask

   task automatic t_global();
      wr_sr(8'h00);
      st(1'b0, spll_pkg::SUM_NONE);
      rd_prot(8'h3f, spll_pkg::PROT_OFF_BYTE);
      wr_sr(8'h7f);
      st(1'b0, spll_pkg::SUM_ALL);
      rd_sr({1'b0, 2'h0, 1'b0, spll_pkg::SUM_ALL, 2'h0});
   endtask

   task automatic t_soft();
      wr_sr(8'hf0);
      st(1'b1, spll_pkg::SUM_ALL);
      chk({7'h0, sw_locked}, 8'h01);
      cmd(spll_pkg::OP_UNPROTECT, 8'h07, 3, 0);
      rd_prot(8'h07, spll_pkg::PROT_ON_BYTE);
      wr_sr(8'h00);
      st(1'b0, spll_pkg::SUM_ALL);
      wr_sr(8'h80);
      st(1'b1, spll_pkg::SUM_NONE);
      wr_sr(8'h0f);
      st(1'b0, spll_pkg::SUM_NONE);
   endtask

   task automatic t_hard();
      wr_sr(8'hff);
      st(1'b1, spll_pkg::SUM_ALL);
      wp_n = 1'b0;
      repeat (6) @(negedge core_clk);
      chk({7'h0, hw_locked}, 8'h01);
      st(1'b1, spll_pkg::SUM_ALL);
      rd_sr({1'b1, 2'h0, 1'b1, spll_pkg::SUM_ALL, 2'h0});
      wr_sr(8'h00);
      st(1'b1, spll_pkg::SUM_ALL);
      cmd(spll_pkg::OP_UNPROTECT, 8'h01, 3, 0);
      rd_prot(8'h01, spll_pkg::PROT_ON_BYTE);
      do_reset();
      st(1'b0, spll_pkg::SUM_ALL);
      chk({7'h0, hw_locked}, 8'h00);
      wp_n = 1'b1;
   endtask

   // release in mid-byte, then a whole read must still work
   task automatic t_abort();
      cmd(spll_pkg::OP_RD_PROT, 8'h02, 3, 1);
      host.shift(8'h00, 3, r);
      host.close_f();
      chk({7'h0, miso_oe_n}, 8'h01);
      rd_prot(8'h02, spll_pkg::PROT_ON_BYTE);
   endtask

   initial
   begin
      wp_n = 1'b1;
      do_reset();
      t_sector();
      t_global();
      t_soft();
      t_hard();
      t_abort();
      print_verdict();
   end
endmodule // spll_top_test
